/* shared/lcd_addr_params.svh */
`ifndef LCD_ADDR_PARAMS_SVH
`define LCD_ADDR_PARAMS_SVH
// Command patterns
`define START_CMD_MASK 8'hE0
`define START_CMD_CODE 8'hC0
`define PAGE_CMD_MASK 8'hFC
`define PAGE_CMD_CODE 8'hB8
`define DUTY_CMD_MASK 8'hFE
`define DUTY_CMD_CODE 8'hA8
// Reset values
`define FIRST_ROW_RESET 5'h00
`define PAGE_RESET 2'h3
`define DUTY_RESET 1'h1
`define PAGE_BASE_RESET 5'h18
`define PINS_IDLE 3'h7
`define DB_IDLE 8'hFF
// Synchronised control pin positions
`define PIN_SELECT 2
`define PIN_READ_N 1
`define PIN_WRITE_N 0
// Geometry
`define ROWS_PER_PAGE 8
`define HALF_ROWS 5'h10
`define HALF_MASK 5'h0F
// Host register map (byte offsets)
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_VIEW 4'h8
// Control register fields
`define CTRL_GO_BIT 8
`define CTRL_RNW_BIT 9
`define CTRL_CD_BIT 10
`endif

/* shared/lcd_addr_pkg.sv */
`default_nettype none
package lcd_addr_pkg;
  typedef logic [4:0] row_t;
  typedef logic [1:0] page_t;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_SETUP,
    BUS_STROBE,
    BUS_HOLD
  } bus_state_e;
endpackage
`default_nettype wire

/* shared/lcd_addr_if.sv */
`default_nettype none
interface lcd_addr_if;
  logic select_cd;
  logic read_n;
  logic write_n;
  logic [7:0] db_to_dev;
  logic [7:0] db_from_dev;
  logic db_from_dev_oe_n;
  modport dev (
    input select_cd, read_n, write_n, db_to_dev,
    output db_from_dev, db_from_dev_oe_n
  );
  modport host (
    output select_cd, read_n, write_n, db_to_dev,
    input db_from_dev, db_from_dev_oe_n
  );
endinterface
`default_nettype wire

/* hw/lcd_addr_dev.sv */
// Summary of operation
// [R1] Five-bit start line names first common row
// [R2] Displayed block is 32 or 16 rows
// [R3] Common n shows row start+n mod 32
// [R4] Only first sixteen mapped rows driven here
// [R5] Host command: select low, read high, write low
// [R6] Code 110xxxxx loads start line
// [R7] Memory is four pages of 80 columns
// [R8] Page p covers rows 8p to 8p+7
// [R9] Host sets page before memory access
// [R10] Code 101110xx loads page register
// [R11] Page bits decode directly to page number
// [R12] Reset clears start line to zero
// [R13] Reset sets page to three
// [R14] Duty high 1/32, low 1/16
// [R15] Byte bit 0 is page's lowest row
// [R16] Other codes leave both registers unchanged
`include "lcd_addr_params.svh"
`default_nettype none
module lcd_addr_dev
  import lcd_addr_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  lcd_addr_if.dev BUS,
  input wire logic [4:0] COMMON_INDEX,
  output logic [4:0] FIRST_ROW,
  output logic [1:0] PAGE_SEL,
  output logic DUTY_32,
  output logic [4:0] MAPPED_ROW,
  output logic MAPPED_VALID,
  output logic [4:0] PAGE_BASE_ROW
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Host strobes are asynchronous to CLK: two stages before any decode
  logic [2:0] ctrl_meta_reg;
  logic [2:0] ctrl_sync_reg;
  logic [7:0] db_meta_reg;
  logic [7:0] db_sync_reg;
  logic write_n_last_reg;
  // Reset to idle levels so no false strobe edge follows reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_meta_reg <= `PINS_IDLE;
      ctrl_sync_reg <= `PINS_IDLE;
    end else begin
      ctrl_meta_reg <= {BUS.select_cd, BUS.read_n, BUS.write_n};
      ctrl_sync_reg <= ctrl_meta_reg;
    end
  end
  // Data settles long before the strobe falls, so bit skew is harmless
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      db_meta_reg <= `DB_IDLE;
      db_sync_reg <= `DB_IDLE;
    end else begin
      db_meta_reg <= BUS.db_to_dev;
      db_sync_reg <= db_meta_reg;
    end
  end
  logic select_sync;
  logic read_n_sync;
  logic write_n_sync;
  assign select_sync = ctrl_sync_reg[`PIN_SELECT];
  assign read_n_sync = ctrl_sync_reg[`PIN_READ_N];
  assign write_n_sync = ctrl_sync_reg[`PIN_WRITE_N];
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      write_n_last_reg <= 1'b1;
    end else begin
      write_n_last_reg <= write_n_sync;
    end
  end
  // Command taken on the write strobe's falling edge only once
  logic cmd_stb;
  logic [7:0] cmd_byte;
  assign cmd_byte = db_sync_reg;
  assign cmd_stb = write_n_last_reg && !write_n_sync && read_n_sync
                   && !select_sync; // see [R5]
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  function automatic logic is_start_cmd(input logic [7:0] b);
    return (b & `START_CMD_MASK) == `START_CMD_CODE;
  endfunction
  function automatic logic is_page_cmd(input logic [7:0] b);
    return (b & `PAGE_CMD_MASK) == `PAGE_CMD_CODE;
  endfunction
  function automatic logic is_duty_cmd(input logic [7:0] b);
    return (b & `DUTY_CMD_MASK) == `DUTY_CMD_CODE;
  endfunction
  logic start_hit;
  logic page_hit;
  logic duty_hit;
  assign start_hit = cmd_stb && is_start_cmd(cmd_byte);
  assign page_hit = cmd_stb && is_page_cmd(cmd_byte);
  assign duty_hit = cmd_stb && is_duty_cmd(cmd_byte);
  // ----------------------------------------
  // Command registers
  // ----------------------------------------
  // Unknown codes hit no pattern, so every register keeps its value
  logic [4:0] first_row_reg;
  logic [1:0] page_reg;
  logic duty_reg;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      first_row_reg <= `FIRST_ROW_RESET; // see [R12]
    end else if (start_hit) begin
      first_row_reg <= cmd_byte[4:0]; // see [R1] see [R6] see [R16]
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      page_reg <= `PAGE_RESET; // see [R13]
    end else if (page_hit) begin
      page_reg <= cmd_byte[1:0]; // see [R10] see [R11] see [R16]
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      duty_reg <= `DUTY_RESET;
    end else if (duty_hit) begin
      duty_reg <= cmd_byte[0]; // see [R14]
    end
  end
  // ----------------------------------------
  // Row mapping
  // ----------------------------------------
  // Five-bit add wraps row 31 to row 0 for free
  logic [4:0] row_next;
  logic [4:0] row_full;
  logic [4:0] row_half;
  assign row_full = first_row_reg + COMMON_INDEX; // see [R3]
  // Short block: wrap inside 16 rows from the start line
  assign row_half = first_row_reg + (COMMON_INDEX & `HALF_MASK); // see [R2]
  always_comb begin
    row_next = row_full;
    if (!duty_reg) begin
      row_next = row_half; // see [R14]
    end
  end
  // ----------------------------------------
  // Display outputs
  // ----------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MAPPED_ROW <= `FIRST_ROW_RESET;
    end else begin
      MAPPED_ROW <= row_next;
    end
  end
  // Upper common positions belong to another chip; flag them
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MAPPED_VALID <= 1'b0;
    end else begin
      MAPPED_VALID <= COMMON_INDEX < `HALF_ROWS; // see [R4]
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      FIRST_ROW <= `FIRST_ROW_RESET;
    end else begin
      FIRST_ROW <= first_row_reg;
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PAGE_SEL <= `PAGE_RESET;
    end else begin
      PAGE_SEL <= page_reg;
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DUTY_32 <= `DUTY_RESET;
    end else begin
      DUTY_32 <= duty_reg;
    end
  end
  // Page p base row is 8p; bit 0 of a byte is this row
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PAGE_BASE_ROW <= `PAGE_BASE_RESET;
    end else begin
      PAGE_BASE_ROW <= {page_reg, 3'h0}; // see [R7] see [R8] see [R15]
    end
  end
  // ----------------------------------------
  // Status bus
  // ----------------------------------------
  // Status readback not part of this block; data pins stay released
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BUS.db_from_dev <= 8'h00;
      BUS.db_from_dev_oe_n <= 1'b1;
    end else begin
      BUS.db_from_dev <= 8'h00;
      BUS.db_from_dev_oe_n <= 1'b1;
    end
  end
endmodule // lcd_addr_dev
`default_nettype wire

/* hw/lcd_addr_host.sv */
`include "lcd_addr_params.svh"
`default_nettype none
module lcd_addr_host
  import lcd_addr_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  lcd_addr_if.host BUS,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  // ----------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------
  logic aw_got_reg;
  logic w_got_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [10:0] ctrl_reg;
  logic [4:0] view_row_reg;
  logic [1:0] view_page_reg;
  bus_state_e state_reg;
  logic busy;
  assign busy = state_reg != BUS_IDLE;
  logic both_in;
  assign both_in = aw_got_reg && w_got_reg && !BVALID;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= 2'h0;
    end else begin
      AWREADY <= !aw_got_reg && !AWREADY && AWVALID;
      WREADY <= !w_got_reg && !WREADY && WVALID;
      if (AWVALID && AWREADY) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got_reg <= 1'b1;
        w_data_reg <= WDATA;
      end
      if (both_in) begin
        BVALID <= 1'b1;
        BRESP <= (aw_addr_reg == `REG_CTRL || aw_addr_reg == `REG_STAT
                  || aw_addr_reg == `REG_VIEW) ? 2'h0 : 2'h2;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
    end
  end
  // Control write with CTRL_GO_BIT set launches one bus cycle; ignored while one runs
  logic launch;
  assign launch = both_in && aw_addr_reg == `REG_CTRL && !busy && WSTRB != 4'h0
                  && w_data_reg[`CTRL_GO_BIT];
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg <= 11'h0;
    end else if (launch) begin
      ctrl_reg <= w_data_reg[10:0];
    end
  end
  // Shadow of the start line and page the device now holds, for software
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      view_row_reg <= `FIRST_ROW_RESET;
      view_page_reg <= `PAGE_RESET;
    end else if (state_reg == BUS_HOLD && !ctrl_reg[`CTRL_CD_BIT]
                 && !ctrl_reg[`CTRL_RNW_BIT]) begin
      if ((ctrl_reg[7:0] & `START_CMD_MASK) == `START_CMD_CODE) begin
        view_row_reg <= ctrl_reg[4:0]; // see [R6]
      end
      if ((ctrl_reg[7:0] & `PAGE_CMD_MASK) == `PAGE_CMD_CODE) begin
        view_page_reg <= ctrl_reg[1:0]; // see [R9] see [R10]
      end
    end
  end
  // ----------------------------------------
  // Parallel bus sequencer
  // ----------------------------------------
  // Strobe held 4 cycles per phase so the device's two-stage sampling sees it
  logic [1:0] phase_cnt_reg;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= BUS_IDLE;
      phase_cnt_reg <= 2'h0;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 2'h1;
      case (state_reg)
        BUS_IDLE: begin
          phase_cnt_reg <= 2'h0;
          if (launch) begin
            state_reg <= BUS_SETUP;
          end
        end
        BUS_SETUP: if (phase_cnt_reg == 2'h3) state_reg <= BUS_STROBE;
        BUS_STROBE: if (phase_cnt_reg == 2'h3) state_reg <= BUS_HOLD;
        BUS_HOLD: if (phase_cnt_reg == 2'h3) state_reg <= BUS_IDLE;
        default: state_reg <= BUS_IDLE;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BUS.select_cd <= 1'b1;
      BUS.read_n <= 1'b1;
      BUS.write_n <= 1'b1;
      BUS.db_to_dev <= 8'h00;
    end else begin
      BUS.select_cd <= busy ? ctrl_reg[`CTRL_CD_BIT] : 1'b1;
      BUS.read_n <= 1'b1; // see [R5]
      BUS.write_n <= !(state_reg == BUS_STROBE && !ctrl_reg[`CTRL_RNW_BIT]); // see [R5]
      BUS.db_to_dev <= ctrl_reg[7:0];
    end
  end
  // ----------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= 2'h0;
    end else begin
      ARREADY <= !ARREADY && !RVALID && ARVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP <= 2'h0;
        case (ARADDR)
          `REG_CTRL: RDATA <= {21'h0, ctrl_reg};
          `REG_STAT: RDATA <= {31'h0, busy};
          `REG_VIEW: RDATA <= {24'h0, 1'b0, view_page_reg, view_row_reg};
          default: begin
            RDATA <= 32'h0;
            RRESP <= 2'h2;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end
endmodule // lcd_addr_host
`default_nettype wire

/* verif/lcd_addr_checker.sv */
`default_nettype none
module lcd_addr_checker (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic select_cd,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [7:0] db_to_dev,
  input wire logic db_from_dev_oe_n,
  input wire logic [4:0] FIRST_ROW,
  input wire logic [1:0] PAGE_SEL
);
  // --------
  // Pin timing and register loads
  // --------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire logic st = !select_cd && db_to_dev[7:5] == 3'b110;
  wire logic pg = !select_cd && db_to_dev[7:2] == 6'b101110;
  AST_READ_IDLE: assert property (read_n && db_from_dev_oe_n)
    else $error("read strobe or data drive active");
  AST_SETUP: assert property (
    $fell(write_n) |-> $stable(select_cd) && $stable(db_to_dev))
    else $error("select or data moved at strobe");
  AST_STROBE: assert property (
    $fell(write_n) |-> !write_n [*4] ##1 write_n)
    else $error("write strobe width wrong");
  AST_HOLD: assert property (
    $rose(write_n) |-> ##1 ($stable(db_to_dev) && $stable(select_cd)) [*3])
    else $error("data not held after strobe");
  AST_START_LOAD: assert property (
    $fell(write_n) && st |-> ##[1:6] FIRST_ROW == db_to_dev[4:0])
    else $error("start line not loaded");
  AST_PAGE_LOAD: assert property (
    $fell(write_n) && pg |-> ##[1:6] PAGE_SEL == db_to_dev[1:0])
    else $error("page not loaded");
  AST_KEEP: assert property (
    $fell(write_n) && !st && !pg |-> ($stable(FIRST_ROW) && $stable(PAGE_SEL)) [*8])
    else $error("register moved on other code");
  AST_RESET: assert property (
    $rose(NRST) |-> FIRST_ROW == 5'h00 && PAGE_SEL == 2'h3)
    else $error("reset values wrong");
endmodule // lcd_addr_checker
`default_nettype wire

/* verif/tb_start_line_and_page_addressing.sv */
`include "lcd_addr_params.svh"
`default_nettype none
module tb_start_line_and_page_addressing
  import lcd_addr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, NRST = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic DUTY_32, MAPPED_VALID;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0;
  logic [31:0] WDATA = 32'h0, RDATA, d;
  logic [1:0] BRESP, RRESP, PAGE_SEL, r, ep = 2'h3;
  logic [4:0] COMMON_INDEX = 5'h00, FIRST_ROW, MAPPED_ROW, PAGE_BASE_ROW, er = 5'h00;
  logic ed = 1'b1;
  logic [9:0] x;
  logic [7:0] rb;
  logic [6:0] prev = 7'h60;
  logic [6:0] notes[$];
  int n_mismatch = 0, check_count = 0, seed = 18;
  lcd_addr_if bus();
  lcd_addr_dev i_lcd_addr_dev (.CLK(CLK), .NRST(NRST), .BUS(bus), .COMMON_INDEX(COMMON_INDEX),
    .FIRST_ROW(FIRST_ROW), .PAGE_SEL(PAGE_SEL), .DUTY_32(DUTY_32), .MAPPED_ROW(MAPPED_ROW),
    .MAPPED_VALID(MAPPED_VALID), .PAGE_BASE_ROW(PAGE_BASE_ROW));
  lcd_addr_host i_lcd_addr_host (.CLK(CLK), .NRST(NRST), .BUS(bus), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY));
  lcd_addr_checker i_lcd_addr_checker (.CLK(CLK), .NRST(NRST), .select_cd(bus.select_cd),
    .read_n(bus.read_n), .write_n(bus.write_n), .db_to_dev(bus.db_to_dev),
    .db_from_dev_oe_n(bus.db_from_dev_oe_n), .FIRST_ROW(FIRST_ROW), .PAGE_SEL(PAGE_SEL));
  // --------
  // Checking and bus tasks
  // --------
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 60) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] e);
    int n;
    @(posedge CLK);
    n = 0;
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID && n < 60);
    BREADY <= 1'b0;
    guard(n);
    check("bresp", BRESP, e);
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    @(posedge CLK);
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID && n < 60);
    RREADY <= 1'b0;
    guard(n);
    d = RDATA;
    r = RRESP;
  endtask
  // Model of the three registers; a note only when the start line or page really moves
  task automatic note(input logic cd, input logic [7:0] b);
    if (!cd && b[7:5] == 3'b110 && b[4:0] != er) begin
      er = b[4:0];
      notes.push_back({ep, er});
    end
    if (!cd && b[7:2] == 6'b101110 && b[1:0] != ep) begin
      ep = b[1:0];
      notes.push_back({ep, er});
    end
    if (!cd && b[7:1] == 7'h54) ed = b[0];
  endtask
  task automatic idle_and_map();
    logic [4:0] n;
    logic [4:0] m;
    int k;
    k = 0;
    d = 32'h1;
    while (d[0] && k < 60) begin
      axi_rd(`REG_STAT);
      k++;
    end
    guard(k);
    n = 5'($random(seed));
    COMMON_INDEX <= n;
    repeat (3) @(posedge CLK);
    // Row numbers wrap at 32, so the sum is cut to five bits
    m = ed ? 5'(er + n) : 5'(er + {1'b0, n[3:0]});
    check("mapped row", MAPPED_ROW, m);
    check("mapped valid", MAPPED_VALID, n < 5'h10);
    check("page base", PAGE_BASE_ROW, {ep, 3'h0});
    check("duty", DUTY_32, ed);
  endtask
  task automatic send(input logic cd, input logic [7:0] b);
    note(cd, b);
    axi_wr(`REG_CTRL, {21'h0, cd, 2'b01, b}, 2'h0);
    idle_and_map();
  endtask
  task automatic do_reset();
    NRST <= 1'b0;
    repeat (20) @(posedge CLK);
    notes.delete();
    {ep, er, ed} = 8'hC1;
    NRST <= 1'b1;
    @(posedge CLK);
    check("reset regs", {PAGE_SEL, FIRST_ROW, DUTY_32, PAGE_BASE_ROW}, 13'h1838);
  endtask
  // --------
  // Result monitor and stimulus
  // --------
  always @(posedge CLK) begin
    if (!NRST) begin
      prev <= 7'h60;
    end else if ({PAGE_SEL, FIRST_ROW} !== prev) begin
      prev <= {PAGE_SEL, FIRST_ROW};
      if (notes.size() == 0) check("spurious update", {PAGE_SEL, FIRST_ROW}, prev);
      else check("row and page", {PAGE_SEL, FIRST_ROW}, notes.pop_front());
    end
  end
  initial begin
    forever #25 CLK = ~CLK;
  end
  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) send(1'b0, 8'hB8 + 8'(i));
    send(1'b0, 8'hDF);
    send(1'b0, 8'hA8);
    send(1'b0, 8'hC0);
    send(1'b0, 8'hA9);
    // Second command while busy must be dropped
    note(1'b0, 8'hC7);
    axi_wr(`REG_CTRL, 32'h1C7, 2'h0);
    axi_wr(`REG_CTRL, {22'h0, 2'b01, 6'b101110, ~ep}, 2'h0);
    idle_and_map();
    axi_rd(`REG_VIEW);
    check("view", d[6:0], {ep, er});
    axi_wr(4'hC, 32'h0, 2'h2);
    axi_rd(4'hC);
    check("rresp", r, 2'h2);
    for (int i = 0; i < 24; i++) begin
      x = 10'($random(seed));
      rb = x[9] ? x[7:0] : x[8] ? {6'b101110, x[1:0]} : {3'b110, x[4:0]};
      send(x[9] & x[8], rb);
    end
    do_reset();
    check("notes left", notes.size(), 0);
    wrap_up();
  end
endmodule // tb_start_line_and_page_addressing
`default_nettype wire
